/* File: rtl/cfd_pkg.sv */
// shared constants, register map and operation codes for the flag datapath
package cfd_pkg;
  // register byte offsets on the axi4-lite slave
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_OPA    = 8'h04;
  localparam logic [7:0] OFS_OPB    = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0C;
  localparam logic [7:0] OFS_CCR    = 8'h10;
  localparam logic [7:0] OFS_ADDR   = 8'h14;
  localparam logic [7:0] OFS_ACC    = 8'h18;
  localparam logic [7:0] OFS_ALIGN  = 8'h1C;
  localparam logic [7:0] OFS_IMAGE  = 8'h20;
  localparam int         ADDR_LSB   = 2;
  localparam int         ADDR_MSB   = 7;
  // control field positions
  localparam int         CTRL_OP_LO = 0;
  localparam int         CTRL_OP_HI = 4;
  localparam int         CTRL_WD_LO = 8;
  localparam int         CTRL_WD_HI = 9;
  localparam int         ACC_SZ_LO  = 0;
  localparam int         ACC_SZ_HI  = 1;
  localparam int         ACC_FETCH  = 2;
  // condition-code bit positions
  localparam int         CCR_I  = 7;
  localparam int         CCR_UI = 6;
  localparam int         CCR_H  = 5;
  localparam int         CCR_U  = 4;
  localparam int         CCR_N  = 3;
  localparam int         CCR_Z  = 2;
  localparam int         CCR_V  = 1;
  localparam int         CCR_C  = 0;
  // half-carry watch bits per width
  localparam int         HALF_BYTE = 3;
  localparam int         HALF_WORD = 11;
  localparam int         HALF_LONG = 27;
  // packed bcd correction constants
  localparam logic [3:0] BCD_MAX  = 4'h9;
  localparam logic [7:0] BCD_LO   = 8'h06;
  localparam logic [7:0] BCD_HI   = 8'h60;
  localparam logic [7:0] BCD_TOP  = 8'h99;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [1:0] {
    WD_BYTE = 2'b00,
    WD_WORD = 2'b01,
    WD_LONG = 2'b10
  } cfd_width_t;
  typedef enum logic [4:0] {
    OP_ADD  = 5'b00000, OP_SUB  = 5'b00001, OP_ADDX = 5'b00010, OP_SUBX = 5'b00011,
    OP_SHL  = 5'b00100, OP_SHR  = 5'b00101, OP_ROTL = 5'b00110, OP_ROTR = 5'b00111,
    OP_AND  = 5'b01000, OP_OR   = 5'b01001, OP_XOR  = 5'b01010, OP_DAA  = 5'b01011,
    OP_DAS  = 5'b01100, OP_BLD  = 5'b01101, OP_BST  = 5'b01110, OP_BAND = 5'b01111,
    OP_BOR  = 5'b10000, OP_BXOR = 5'b10001, OP_BSET = 5'b10010, OP_BCLR = 5'b10011,
    OP_BNOT = 5'b10100, OP_BTST = 5'b10101, OP_LDC  = 5'b10110, OP_AND_CONDITION_CODE = 5'b10111,
    OP_ORC  = 5'b11000, OP_XOR_CONDITION_CODE = 5'b11001
  } cfd_op_t;
endpackage

/* File: rtl/cfd_alu.sv */
// combinational arithmetic, bit and bcd unit with condition-code generation
`timescale 1ns/10ps
module cfd_alu (
  input  wire logic [4:0]  op_code,
  input  wire logic [1:0]  width,
  input  wire logic [31:0] opa,
  input  wire logic [31:0] opb,
  input  wire logic [7:0]  ccr_in,
  output logic      [31:0] result,
  output logic      [7:0]  ccr_out
);
  logic [4:0]  msb;
  logic [31:0] mask;
  logic [4:0]  half;
  logic        cin;
  logic [32:0] a_x;
  logic [32:0] b_x;
  logic [32:0] sum;
  logic [32:0] dif;
  logic [32:0] hx_sum;
  logic [32:0] hx_dif;
  logic [2:0]  idx;
  logic        bit_v;
  logic [7:0]  onehot;
  logic [7:0]  byte_a;
  logic        lo_big;
  logic        hi_big;

  // width decode, operands trimmed to the working width
  assign msb    = (width == cfd_pkg::WD_BYTE) ? 5'h07 :
                  (width == cfd_pkg::WD_WORD) ? 5'h0F : 5'h1F;
  assign mask   = (width == cfd_pkg::WD_BYTE) ? 32'h0000_00FF :
                  (width == cfd_pkg::WD_WORD) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
  assign half   = (width == cfd_pkg::WD_BYTE) ? 5'(cfd_pkg::HALF_BYTE + 1) :
                  (width == cfd_pkg::WD_WORD) ? 5'(cfd_pkg::HALF_WORD + 1) :
                  5'(cfd_pkg::HALF_LONG + 1);
  assign cin    = ((op_code == cfd_pkg::OP_ADDX) || (op_code == cfd_pkg::OP_SUBX))
                  ? ccr_in[cfd_pkg::CCR_C] : 1'b0;
  assign a_x    = {1'b0, opa & mask};
  assign b_x    = {1'b0, opb & mask};
  assign sum    = a_x + b_x + {32'h0000_0000, cin};
  assign dif    = a_x - b_x - {32'h0000_0000, cin};
  // carry into each bit; one bit of it is picked as half carry
  assign hx_sum = a_x ^ b_x ^ sum;
  assign hx_dif = a_x ^ b_x ^ dif;
  // single bit selection inside the low byte
  assign idx    = opb[2:0];
  assign byte_a = opa[7:0];
  assign bit_v  = byte_a[idx];
  assign onehot = 8'h01 << idx;
  assign lo_big = byte_a[3:0] > cfd_pkg::BCD_MAX;
  assign hi_big = byte_a > cfd_pkg::BCD_TOP;

  // per-operation result and flags; untouched bits keep ccr_in
  always_comb begin
    logic [31:0] r;
    logic [7:0]  c;
    logic [7:0]  adj;
    logic        arith;
    r     = opa;
    c     = ccr_in;
    adj   = 8'h00;
    arith = 1'b1;
    unique case (op_code)
      cfd_pkg::OP_ADD, cfd_pkg::OP_ADDX: begin
        r                  = sum[31:0] & mask;
        c[cfd_pkg::CCR_C]  = sum[6'(msb) + 6'h01];
        c[cfd_pkg::CCR_H]  = hx_sum[half];
        c[cfd_pkg::CCR_V]  = (opa[msb] == opb[msb]) && (r[msb] != opa[msb]);
      end
      cfd_pkg::OP_SUB, cfd_pkg::OP_SUBX: begin
        r                  = dif[31:0] & mask;
        c[cfd_pkg::CCR_C]  = dif[6'(msb) + 6'h01];
        c[cfd_pkg::CCR_H]  = hx_dif[half];
        c[cfd_pkg::CCR_V]  = (opa[msb] != opb[msb]) && (r[msb] != opa[msb]);
      end
      cfd_pkg::OP_SHL, cfd_pkg::OP_ROTL: begin
        r                  = ((opa << 1) | ((op_code == cfd_pkg::OP_ROTL) ?
                             {31'h0000_0000, opa[msb]} : 32'h0000_0000)) & mask;
        c[cfd_pkg::CCR_C]  = opa[msb];
        c[cfd_pkg::CCR_V]  = 1'b0;
      end
      cfd_pkg::OP_SHR, cfd_pkg::OP_ROTR: begin
        r                  = ((opa & mask) >> 1) | ((op_code == cfd_pkg::OP_ROTR) ?
                             (32'(opa[0]) << msb) : 32'h0000_0000);
        c[cfd_pkg::CCR_C]  = opa[0];
        c[cfd_pkg::CCR_V]  = 1'b0;
      end
      cfd_pkg::OP_AND, cfd_pkg::OP_OR, cfd_pkg::OP_XOR: begin
        r = (op_code == cfd_pkg::OP_AND) ? (opa & opb & mask) :
            (op_code == cfd_pkg::OP_OR)  ? ((opa | opb) & mask) : ((opa ^ opb) & mask);
        c[cfd_pkg::CCR_V] = 1'b0;
      end
      cfd_pkg::OP_DAA: begin
        // two packed digits: both corrections chosen from the original byte, added in one step
        adj = ((ccr_in[cfd_pkg::CCR_H] || lo_big) ? cfd_pkg::BCD_LO : 8'h00) |
              ((ccr_in[cfd_pkg::CCR_C] || hi_big) ? cfd_pkg::BCD_HI : 8'h00);
        r   = {24'h00_0000, byte_a + adj};
        c[cfd_pkg::CCR_C] = ccr_in[cfd_pkg::CCR_C] || hi_big;
      end
      cfd_pkg::OP_DAS: begin
        adj = (ccr_in[cfd_pkg::CCR_H] ? cfd_pkg::BCD_LO : 8'h00) |
              (ccr_in[cfd_pkg::CCR_C] ? cfd_pkg::BCD_HI : 8'h00);
        r   = {24'h00_0000, byte_a - adj};
      end
      // carry acts as a one-bit accumulator for BLD, BAND, BOR and BXOR
      cfd_pkg::OP_BLD:  begin arith = 1'b0; c[cfd_pkg::CCR_C] = bit_v; end
      cfd_pkg::OP_BAND: begin arith = 1'b0; c[cfd_pkg::CCR_C] = c[cfd_pkg::CCR_C] & bit_v; end
      cfd_pkg::OP_BOR:  begin arith = 1'b0; c[cfd_pkg::CCR_C] = c[cfd_pkg::CCR_C] | bit_v; end
      cfd_pkg::OP_BXOR: begin arith = 1'b0; c[cfd_pkg::CCR_C] = c[cfd_pkg::CCR_C] ^ bit_v; end
      cfd_pkg::OP_BST: begin
        arith = 1'b0;
        r     = {opa[31:8], ccr_in[cfd_pkg::CCR_C] ? (byte_a | onehot) : (byte_a & ~onehot)};
      end
      cfd_pkg::OP_BSET: begin arith = 1'b0; r = {opa[31:8], byte_a | onehot}; end
      cfd_pkg::OP_BCLR: begin arith = 1'b0; r = {opa[31:8], byte_a & ~onehot}; end
      cfd_pkg::OP_BNOT: begin arith = 1'b0; r = {opa[31:8], byte_a ^ onehot}; end
      cfd_pkg::OP_BTST: begin arith = 1'b0; c[cfd_pkg::CCR_Z] = ~bit_v; end
      cfd_pkg::OP_LDC:  begin arith = 1'b0; c = opb[7:0]; end
      cfd_pkg::OP_AND_CONDITION_CODE: begin arith = 1'b0; c = ccr_in & opb[7:0]; end
      cfd_pkg::OP_ORC:  begin arith = 1'b0; c = ccr_in | opb[7:0]; end
      cfd_pkg::OP_XOR_CONDITION_CODE: begin arith = 1'b0; c = ccr_in ^ opb[7:0]; end
      default:          begin arith = 1'b0; end
    endcase
    // sign and zero follow the result at the working width
    if (arith) begin
      c[cfd_pkg::CCR_N] = r[msb];
      c[cfd_pkg::CCR_Z] = ((r & mask) == 32'h0000_0000);
    end
    result  = r;
    ccr_out = c;
  end
endmodule

/* File: rtl/cfd_top.sv */
// axi4-lite wrapper: flag datapath, condition-code register, address aligner
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/10ps
// Operation
// - sign flag takes result msb at operand width
// - zero flag set when result is all zeros, else cleared
// - overflow flag set on signed arithmetic overflow, cleared otherwise
// - carry set on add carry, subtract borrow, or one shifted out
// - bit operations use carry as one-bit source and destination
// - bit operations select bit 0 to 7 of a byte, touch only it
// - decimal adjust treats byte as two packed bcd digits
// - operands of 1, 4, 8, 16 and 32 bits are handled
// - odd word or longword access forces address bit 0 low, no error
// - instruction fetch from odd address also forces bit 0 low
// - user bits have no hardware effect, software reads and writes them
// - reset sets interrupt mask bit, other bits stay uninitialised
// - half carry from bit 3, 11 or 27 by width
module cfd_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  logic        awready_r;
  logic        wready_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        arready_r;
  logic        rvalid_r;
  logic [1:0]  rresp_r;
  logic [31:0] rdata_r;
  logic        aw_held_r;
  logic        w_held_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic [9:0]  ctrl_r;
  logic [31:0] opa_r;
  logic [31:0] opb_r;
  logic [31:0] result_r;
  logic [7:0]  ccr_r;
  logic [31:0] addr_r;
  logic [2:0]  acc_r;

  // handshake decode
  wire         aw_fire   = s_axi_awvalid & awready_r;
  wire         w_fire    = s_axi_wvalid & wready_r;
  wire         ar_fire   = s_axi_arvalid & arready_r;
  wire         wr_do     = aw_held_r & w_held_r & ~bvalid_r;
  wire         aw_held_nxt = (aw_held_r & ~wr_do) | aw_fire;
  wire         w_held_nxt  = (w_held_r & ~wr_do) | w_fire;
  wire         bvalid_nxt  = wr_do | (bvalid_r & ~s_axi_bready);
  wire         rvalid_nxt  = ar_fire | (rvalid_r & ~s_axi_rready);
  wire [31:0]  wmask     = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

  // write address decode on the captured offset
  wire [7:0]   wofs      = {awaddr_r[cfd_pkg::ADDR_MSB:cfd_pkg::ADDR_LSB], 2'b00};
  wire         w_ctrl    = wr_do & (wofs == cfd_pkg::OFS_CTRL);
  wire         w_opa     = wr_do & (wofs == cfd_pkg::OFS_OPA);
  wire         w_opb     = wr_do & (wofs == cfd_pkg::OFS_OPB);
  wire         w_ccr     = wr_do & (wofs == cfd_pkg::OFS_CCR);
  wire         w_addr    = wr_do & (wofs == cfd_pkg::OFS_ADDR);
  wire         w_acc     = wr_do & (wofs == cfd_pkg::OFS_ACC);
  wire         w_ro      = (wofs == cfd_pkg::OFS_RESULT) | (wofs == cfd_pkg::OFS_ALIGN) |
                           (wofs == cfd_pkg::OFS_IMAGE);
  wire         w_hit     = (wofs == cfd_pkg::OFS_CTRL) | (wofs == cfd_pkg::OFS_OPA) |
                           (wofs == cfd_pkg::OFS_OPB) | (wofs == cfd_pkg::OFS_CCR) |
                           (wofs == cfd_pkg::OFS_ADDR) | (wofs == cfd_pkg::OFS_ACC) | w_ro;
  // an operation runs only when the opcode byte lane is written
  wire         exec      = w_ctrl & wstrb_r[0];

  // merged register values under byte enables
  wire [31:0]  ctrl_in   = ({22'h00_0000, ctrl_r} & ~wmask) | (wdata_r & wmask);
  wire [31:0]  opa_nxt   = (opa_r & ~wmask) | (wdata_r & wmask);
  wire [31:0]  opb_nxt   = (opb_r & ~wmask) | (wdata_r & wmask);
  wire [31:0]  addr_nxt  = (addr_r & ~wmask) | (wdata_r & wmask);
  wire [4:0]   op_sel    = ctrl_in[cfd_pkg::CTRL_OP_HI:cfd_pkg::CTRL_OP_LO];
  wire [1:0]   wd_sel    = ctrl_in[cfd_pkg::CTRL_WD_HI:cfd_pkg::CTRL_WD_LO];

  logic [31:0] alu_result;
  logic [7:0]  alu_ccr;

  // datapath: operands are byte, word or long; bit and bcd forms live in the byte
  cfd_alu u_alu (
    .op_code (op_sel),
    .width   (wd_sel),
    .opa     (opa_r),
    .opb     (opb_r),
    .ccr_in  (ccr_r),
    .result  (alu_result),
    .ccr_out (alu_ccr)
  );

  // address aligner: word, long and fetch accesses drop bit 0, never an error
  wire [1:0]   acc_size  = acc_r[cfd_pkg::ACC_SZ_HI:cfd_pkg::ACC_SZ_LO];
  wire         acc_fetch = acc_r[cfd_pkg::ACC_FETCH];
  wire         force_even = (acc_size != cfd_pkg::WD_BYTE) | acc_fetch;
  wire [31:0]  addr_even = {addr_r[31:1], addr_r[0] & ~force_even};

  // memory image: byte at lowest address carries the most significant byte
  // width of the stored control, not of a write still in flight
  wire [1:0]   cur_wd    = ctrl_r[cfd_pkg::CTRL_WD_HI:cfd_pkg::CTRL_WD_LO];
  wire [1:0]   top_lane  = (cur_wd == cfd_pkg::WD_BYTE) ? 2'h0 :
                           (cur_wd == cfd_pkg::WD_WORD) ? 2'h1 : 2'h3;
  logic [31:0] image;
  genvar gl;
  generate
    for (gl = 0; gl < 4; gl++) begin : g_lane
      wire [1:0] src = top_lane - 2'(gl);
      assign image[8*gl +: 8] = (2'(gl) <= top_lane) ? result_r[8*src +: 8] : 8'h00;
    end
  endgenerate

  // read mux, unmapped offsets answer slverr with zero data
  wire [7:0]   rofs      = {s_axi_araddr[cfd_pkg::ADDR_MSB:cfd_pkg::ADDR_LSB], 2'b00};
  wire         r_hit     = (rofs <= cfd_pkg::OFS_IMAGE) && (s_axi_araddr[31:8] == 24'h00_0000);
  wire         w_map     = w_hit && (awaddr_r == wofs);
  wire [31:0]  rd_mux    = (rofs == cfd_pkg::OFS_CTRL)   ? {22'h00_0000, ctrl_r} :
                           (rofs == cfd_pkg::OFS_OPA)    ? opa_r :
                           (rofs == cfd_pkg::OFS_OPB)    ? opb_r :
                           (rofs == cfd_pkg::OFS_RESULT) ? result_r :
                           (rofs == cfd_pkg::OFS_CCR)    ? {24'h00_0000, ccr_r} :
                           (rofs == cfd_pkg::OFS_ADDR)   ? addr_r :
                           (rofs == cfd_pkg::OFS_ACC)    ? {29'h0000_0000, acc_r} :
                           (rofs == cfd_pkg::OFS_ALIGN)  ? addr_even : image;

  logic aw_hi_zero_r;

  // write channel handshake; response follows both address and data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= cfd_pkg::RESP_OK;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r  <= w_held_nxt;
      awready_r <= ~aw_held_nxt & ~bvalid_nxt;
      wready_r  <= ~w_held_nxt & ~bvalid_nxt;
      bvalid_r  <= bvalid_nxt;
      if (wr_do) begin
        bresp_r <= (w_map && aw_hi_zero_r) ? cfd_pkg::RESP_OK : cfd_pkg::RESP_ERR;
      end
    end
  end

  // captured write payload; upper address bits only checked for range
  always_ff @(posedge aclk) begin
    if (aw_fire) begin
      awaddr_r     <= s_axi_awaddr[7:0];
      aw_hi_zero_r <= (s_axi_awaddr[31:8] == 24'h00_0000);
    end
    if (w_fire) begin
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end
  end

  // read channel: one read at a time, data latched with the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rresp_r   <= cfd_pkg::RESP_OK;
      rdata_r   <= 32'h0000_0000;
    end else begin
      arready_r <= ~rvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      if (ar_fire) begin
        rdata_r <= r_hit ? rd_mux : 32'h0000_0000;
        rresp_r <= r_hit ? cfd_pkg::RESP_OK : cfd_pkg::RESP_ERR;
      end
    end
  end

  // software-visible operand and control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r   <= 10'h000;
      opa_r    <= 32'h0000_0000;
      opb_r    <= 32'h0000_0000;
      result_r <= 32'h0000_0000;
      addr_r   <= 32'h0000_0000;
      acc_r    <= 3'h0;
    end else begin
      if (w_ctrl) ctrl_r <= ctrl_in[9:0];
      if (w_opa)  opa_r  <= opa_nxt;
      if (w_opb)  opb_r  <= opb_nxt;
      if (exec)   result_r <= alu_result;
      if (w_addr) addr_r <= addr_nxt;
      if (w_acc & wstrb_r[0]) acc_r <= wdata_r[2:0];
    end
  end

  // condition codes: only the mask bit is reset, the rest power up unknown;
  // direct load wins over an operation; user bits only move by these paths
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ccr_r[cfd_pkg::CCR_I] <= 1'b1;
    end else if (w_ccr & wstrb_r[0]) begin
      ccr_r[cfd_pkg::CCR_I] <= wdata_r[cfd_pkg::CCR_I];
    end else if (exec) begin
      ccr_r[cfd_pkg::CCR_I] <= alu_ccr[cfd_pkg::CCR_I];
    end
    if (w_ccr & wstrb_r[0]) begin
      ccr_r[6:0] <= wdata_r[6:0];
    end else if (exec) begin
      ccr_r[6:0] <= alu_ccr[6:0];
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;

  // helper state for checks: what the last operation saw
  logic        ran_r;
  logic [4:0]  ran_op_r;
  logic [1:0]  ran_wd_r;
  logic [31:0] ran_a_r;
  logic [31:0] ran_b_r;
  logic [7:0]  ran_c_r;
  always_ff @(posedge aclk) begin
    ran_r    <= aresetn & exec & ~(w_ccr & wstrb_r[0]);
    ran_op_r <= op_sel;
    ran_wd_r <= wd_sel;
    ran_a_r  <= opa_r;
    ran_b_r  <= opb_r;
    ran_c_r  <= ccr_r;
  end
  wire [4:0] ran_msb = (ran_wd_r == cfd_pkg::WD_BYTE) ? 5'h07 :
                       (ran_wd_r == cfd_pkg::WD_WORD) ? 5'h0F : 5'h1F;
  wire       ran_arith = (ran_op_r <= cfd_pkg::OP_XOR);
  wire       ran_bit = (ran_op_r >= cfd_pkg::OP_BST) && (ran_op_r <= cfd_pkg::OP_BNOT) &&
                       (ran_op_r != cfd_pkg::OP_BAND) && (ran_op_r != cfd_pkg::OP_BOR) &&
                       (ran_op_r != cfd_pkg::OP_BXOR);
  wire [8:0] add_byte = {1'b0, ran_a_r[7:0]} + {1'b0, ran_b_r[7:0]};
  wire [4:0] add_nib  = {1'b0, ran_a_r[3:0]} + {1'b0, ran_b_r[3:0]};
  wire [7:0] keep_msk = ~(8'h01 << ran_b_r[2:0]);

  sequence op_ran_s(logic [4:0] o);
    ran_r && (ran_op_r == o);
  endsequence
  sequence byte_add_s;
    op_ran_s(cfd_pkg::OP_ADD) ##0 (ran_wd_r == cfd_pkg::WD_BYTE);
  endsequence

  reset_mask_a: assert property (@(posedge aclk) !aresetn |=> ccr_r[cfd_pkg::CCR_I])
    else $error("mask bit not set after reset");
  align_even_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (acc_size != cfd_pkg::WD_BYTE) |-> (addr_even[0] == 1'b0 && addr_even[31:1] == addr_r[31:1]))
    else $error("word access address not forced even");
  fetch_even_a: assert property (@(posedge aclk) disable iff (!aresetn)
    acc_fetch |-> !addr_even[0])
    else $error("fetch address not forced even");
  sign_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ran_r && ran_arith) |-> (ccr_r[cfd_pkg::CCR_N] == result_r[ran_msb]))
    else $error("sign flag differs from result msb");
  zero_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ran_r && ran_arith && ran_wd_r == cfd_pkg::WD_BYTE) |->
    (ccr_r[cfd_pkg::CCR_Z] == (result_r[7:0] == 8'h00)))
    else $error("zero flag wrong");
  add_carry_a: assert property (@(posedge aclk) disable iff (!aresetn)
    byte_add_s |-> (ccr_r[cfd_pkg::CCR_C] == add_byte[8]) && (result_r[7:0] == add_byte[7:0]))
    else $error("byte add carry wrong");
  half_carry_a: assert property (@(posedge aclk) disable iff (!aresetn)
    byte_add_s |-> (ccr_r[cfd_pkg::CCR_H] == add_nib[4]))
    else $error("byte add half carry wrong");
  add_ovf_a: assert property (@(posedge aclk) disable iff (!aresetn)
    byte_add_s |-> (ccr_r[cfd_pkg::CCR_V] == ((ran_a_r[7] == ran_b_r[7]) &&
                                              (result_r[7] != ran_a_r[7]))))
    else $error("byte add overflow wrong");
  bit_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ran_r && ran_bit) |-> ((result_r[7:0] & keep_msk) == (ran_a_r[7:0] & keep_msk)) &&
    (result_r[31:8] == ran_a_r[31:8]))
    else $error("bit operation touched other bits");
  bit_acc_a: assert property (@(posedge aclk) disable iff (!aresetn)
    op_ran_s(cfd_pkg::OP_BLD) |-> (ccr_r[cfd_pkg::CCR_C] == ran_a_r[ran_b_r[2:0]]))
    else $error("bit load did not reach carry");
  user_bit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ran_r && ran_op_r < cfd_pkg::OP_LDC) |-> (ccr_r[cfd_pkg::CCR_UI] == ran_c_r[cfd_pkg::CCR_UI]))
    else $error("user bit changed by hardware");
  big_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cur_wd == cfd_pkg::WD_LONG) |->
    (image[7:0] == result_r[31:24]) && (image[31:24] == result_r[7:0]))
    else $error("memory image byte order wrong");
endmodule

/* File: tb/cfd_mem_model.sv */
// memory side model: byte order of a value as memory holds it
`timescale 1ns/10ps
module cfd_mem_model (
  input  wire logic [31:0] value,
  input  wire logic [1:0]  width,
  output logic      [31:0] image
);
  // most significant byte in the lowest, even lane; items start even
  always_comb begin
    case (width)
      2'h0:    image = {24'h0, value[7:0]};
      2'h1:    image = {16'h0, value[7:0], value[15:8]};
      default: image = {value[7:0], value[15:8], value[23:16], value[31:24]};
    endcase
  end
endmodule

/* File: tb/tb_cfd_top.sv */
// self-checking bench for the flag datapath over axi4-lite
`timescale 1ns/10ps
module tb_cfd_top;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, img, rv, val;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, wdth, br;
  int          miscompares, check_count;
  cfd_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  cfd_mem_model mem_u (.value(val), .width(wdth), .image(img));
  // 100 mhz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      miscompares++;
    end
  endtask
  task automatic results;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // bready and rready stay high, so each wait ends at the answer edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr  <= {24'h0, a};
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    br = s_axi_bresp;
    if (n == 50) begin
      miscompares++;
      results();
    end
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    s_axi_araddr  <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rv = s_axi_rdata;
    br = s_axi_rresp;
    if (n == 50) begin
      miscompares++;
      results();
    end
  endtask
  // flags chain from row to row, as the condition codes carry over
  task automatic ex(input logic [4:0] op, input logic [1:0] wd, input logic [31:0] a, b, r,
                    input logic [7:0] cc);
    logic [31:0] m;
    m = wd == 2'h0 ? 32'h0000_00ff : wd == 2'h1 ? 32'h0000_ffff : 32'hffff_ffff;
    wr(cfd_pkg::OFS_OPA, a);
    wr(cfd_pkg::OFS_OPB, b);
    wr(cfd_pkg::OFS_CTRL, {22'h0, wd, 3'h0, op});
    rd(cfd_pkg::OFS_RESULT);
    chk(rv & m, r);
    rd(cfd_pkg::OFS_CCR);
    chk({24'h0, rv[7:0]}, {24'h0, cc});
  endtask
  // raw address 0x1235 through the aligner
  task automatic al(input logic [1:0] sz, input logic f, input logic [31:0] exp);
    wr(cfd_pkg::OFS_ADDR, 32'h0000_1235);
    wr(cfd_pkg::OFS_ACC, {29'h0, f, sz});
    rd(cfd_pkg::OFS_ALIGN);
    chk(rv, exp);
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, val, wdth, miscompares, check_count} = '0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(cfd_pkg::OFS_CCR);
    chk({31'h0, rv[7]}, 32'h0000_0001);
    wr(cfd_pkg::OFS_CCR, 32'h0000_0050);
    rd(cfd_pkg::OFS_CCR);
    chk({24'h0, rv[7:0]}, 32'h0000_0050);
    wr(cfd_pkg::OFS_CCR, 32'h0000_0000);
    chk({30'h0, br}, {30'h0, cfd_pkg::RESP_OK});
    $display("test reset and user bits done");
    ex(cfd_pkg::OP_ADD, 2'h0, 32'h0000_007f, 32'h0000_0001, 32'h0000_0080, 8'h2a);
    ex(cfd_pkg::OP_SUB, 2'h0, 32'h0000_0000, 32'h0000_0001, 32'h0000_00ff, 8'h29);
    ex(cfd_pkg::OP_ADD, 2'h1, 32'h0000_ffff, 32'h0000_0001, 32'h0000_0000, 8'h25);
    ex(cfd_pkg::OP_ADD, 2'h2, 32'h7fff_ffff, 32'h0000_0001, 32'h8000_0000, 8'h2a);
    ex(cfd_pkg::OP_SHL, 2'h0, 32'h0000_0081, 32'h0000_0000, 32'h0000_0002, 8'h21);
    ex(cfd_pkg::OP_ADD, 2'h0, 32'h0000_0015, 32'h0000_0027, 32'h0000_003c, 8'h00);
    ex(cfd_pkg::OP_DAA, 2'h0, 32'h0000_003c, 32'h0000_0000, 32'h0000_0042, 8'h00);
    ex(cfd_pkg::OP_SUB, 2'h0, 32'h0000_0042, 32'h0000_0015, 32'h0000_002d, 8'h20);
    ex(cfd_pkg::OP_DAS, 2'h0, 32'h0000_002d, 32'h0000_0000, 32'h0000_0027, 8'h20);
    ex(cfd_pkg::OP_BLD, 2'h0, 32'h0000_0004, 32'h0000_0002, 32'h0000_0004, 8'h21);
    ex(cfd_pkg::OP_BST, 2'h0, 32'h0000_0000, 32'h0000_0005, 32'h0000_0020, 8'h21);
    ex(cfd_pkg::OP_BNOT, 2'h0, 32'h0000_00ff, 32'h0000_0000, 32'h0000_00fe, 8'h21);
    ex(cfd_pkg::OP_ADDX, 2'h0, 32'h10, 32'h20, 32'h31, 8'h00);
    ex(cfd_pkg::OP_SHR, 2'h0, 32'h03, 32'h00, 32'h01, 8'h01);
    ex(cfd_pkg::OP_SUBX, 2'h0, 32'h10, 32'h01, 32'h0e, 8'h20);
    ex(cfd_pkg::OP_ROTR, 2'h0, 32'h01, 32'h00, 32'h80, 8'h29);
    ex(cfd_pkg::OP_ROTL, 2'h1, 32'h8001, 32'h00, 32'h03, 8'h21);
    ex(cfd_pkg::OP_XOR, 2'h0, 32'h5a, 32'h5a, 32'h00, 8'h25);
    ex(cfd_pkg::OP_AND, 2'h1, 32'hff00, 32'h8f0f, 32'h8f00, 8'h29);
    ex(cfd_pkg::OP_BAND, 2'h0, 32'h08, 32'h02, 32'h08, 8'h28);
    ex(cfd_pkg::OP_BXOR, 2'h0, 32'h08, 32'h03, 32'h08, 8'h29);
    ex(cfd_pkg::OP_BTST, 2'h0, 32'h08, 32'h00, 32'h08, 8'h2d);
    ex(cfd_pkg::OP_BCLR, 2'h0, 32'hff, 32'h07, 32'h7f, 8'h2d);
    ex(cfd_pkg::OP_LDC, 2'h0, 32'h00, 32'h45, 32'h00, 8'h45);
    ex(cfd_pkg::OP_AND_CONDITION_CODE, 2'h0, 32'h00, 32'h0f, 32'h00, 8'h05);
    ex(cfd_pkg::OP_XOR_CONDITION_CODE, 2'h0, 32'h00, 32'h05, 32'h00, 8'h00);
    ex(cfd_pkg::OP_ADD, 2'h2, 32'h1234_5600, 32'h0000_0078, 32'h1234_5678, 8'h00);
    $display("test flags done");
    val = 32'h1234_5678;
    wdth = 2'h2;
    rd(cfd_pkg::OFS_IMAGE);
    chk(rv, img);
    al(2'h0, 1'b0, 32'h0000_1235);
    al(2'h1, 1'b0, 32'h0000_1234);
    al(2'h2, 1'b0, 32'h0000_1234);
    al(2'h0, 1'b1, 32'h0000_1234);
    chk({30'h0, br}, {30'h0, cfd_pkg::RESP_OK});
    rd(8'h40);
    chk({30'h0, br}, {30'h0, cfd_pkg::RESP_ERR});
    chk(rv, 32'h0);
    wr(8'h40, 32'h0);
    chk({30'h0, br}, {30'h0, cfd_pkg::RESP_ERR});
    $display("test memory order and alignment done");
    results();
  end
endmodule
